// ===== include/dcbx_pkg.sv
// Constants for the comparator B extension register and its match logic
package dcbx_pkg;
    localparam int DCBX_DATA_W = 32;
    localparam int DCBX_ADDR_W = 8;
    localparam int DCBX_CPU_ADDR_W = 16;
    localparam int DCBX_CORE_ADDR_W = 17;
    localparam int DCBX_PAGE_W = 3;
    localparam int DCBX_PAGE_OFS_W = 14;
    localparam int DCBX_DATA_CMP_W = 8;
    localparam int DCBX_REG_W = 8;

    // Printed offset is a register index; byte address is four times it
    localparam logic [3:0] DCBX_CBX_INDEX = 4'h9;
    localparam logic [7:0] DCBX_CBX_BYTE_ADDR = 8'({4'h0, DCBX_CBX_INDEX} << 2);

    localparam int DCBX_BIT_DIR_EN = 7;
    localparam int DCBX_BIT_DIR_VAL = 6;
    localparam int DCBX_BIT_PAGE_SEL = 5;
    localparam int DCBX_BIT_ADDR16 = 0;
    localparam logic [7:0] DCBX_IMPL_MASK = 8'hE1;
    localparam logic [7:0] DCBX_CBX_RESET = 8'h00;

    // Slave answers with one wait state
    localparam int DCBX_WAIT_CYCLES = 1;
endpackage

// ===== verification/dcbx_core_model.sv
// Core bus model: random cycles that often hit the target address
`timescale 1ns/100ps
`default_nettype none
module dcbx_core_model (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [15:0] hint,
    output logic bus_valid,
    output logic bus_read,
    output logic ppage_sel,
    output logic linear_sel,
    output logic [2:0] ppage,
    output logic [15:0] cpu_addr,
    output logic [16:0] linear_addr,
    output logic [7:0] core_data
);
    int seed = 56520;
    logic [31:0] r;
    initial {bus_valid, bus_read, ppage_sel, linear_sel, ppage, cpu_addr, linear_addr} = '0;
    initial core_data = '0;
    // Lines keep changing when idle so no stale value can pass for a match
    always @(posedge sys_clk) begin
        r = $random(seed);
        bus_valid <= run & r[0];
        bus_read <= r[1];
        ppage_sel <= r[2];
        linear_sel <= r[3];
        ppage <= r[4] ? {r[5], hint[15:14]} : r[7:5];
        cpu_addr <= r[8] ? hint : r[31:16];
        linear_addr <= {r[9], r[10] ? hint : r[31:16]};
        core_data <= r[11] ? hint[7:0] : r[23:16];
    end
endmodule
`default_nettype wire

// ===== verification/dcbx_top_bench.sv
// Self-checking bench for the comparator B extension block
`timescale 1ns/100ps
`default_nettype none
module dcbx_top_bench;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, run = 0;
    logic reset_event = 0, reset_end_run = 0, debug_module_enable = 0, trace_begin = 0;
    logic full_mode = 0, dir_qualify_enable_a = 0, dir_match_value_a = 0;
    logic [7:0] paddr = 0, core_data, mreg = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [15:0] cmp_b_value = 0, hint, cpu_addr;
    logic bus_valid, bus_read, ppage_sel, linear_sel, match_b, er;
    logic dir_qualify_enable_b, dir_match_value_b, page_qualify_select, addr16_value;
    logic [2:0] ppage;
    logic [16:0] linear_addr, core_addr_seen, fa;
    int seed = 56520, fail_count = 0, samples_checked = 0, cyc = 0, ev = -1, i;
    assign hint = cmp_b_value;
    dcbx_top i_dcbx_top (.*);
    dcbx_core_model i_dcbx_core_model (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        if (e !== s) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            fail_count++;
        end
        samples_checked++;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1 && k++ < 20);
        if (pready !== 1'b1) begin
            $display("BAD apb_timeout expected 1 seen %b", pready);
            fail_count++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && a == 8'h24 && pstrb[0]) mreg = d[7:0] & 8'hE1;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            stop_test;
        end
    end
    // Expectation is set from inputs at the negedge before the sampling edge
    always @(negedge sys_clk) begin
        if (nrst && ev >= 0) begin
            chk("match_b", ev[0], match_b);
            chk("core_addr_seen", fa, core_addr_seen);
        end
        fa = ppage_sel ? {ppage, cpu_addr[13:0]} : linear_sel ? linear_addr : {1'b0, cpu_addr};
        if (full_mode) ev = bus_valid && (!dir_qualify_enable_a || bus_read == dir_match_value_a)
            && core_data == cmp_b_value[7:0];
        else ev = bus_valid && (!mreg[7] || bus_read == mreg[6]) && mreg[5] == ppage_sel
            && fa[16] == mreg[0] && fa[15:0] == cmp_b_value;
        if (!nrst) ev = -1;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1;
        apb(0, 8'h24, 0);
        chk("reset value", 0, rd);
        apb(1, 8'h24, 32'hFFFFFFFF);
        apb(0, 8'h24, 0);
        chk("implemented bits", 32'hE1, rd);
        apb(0, 8'h30, 0);
        chk("unmapped error", 1, er);
        for (i = 0; i < 60; i++) begin
            pstrb <= 4'($random(seed));
            apb(1, 8'h24, $random(seed));
            {full_mode, dir_qualify_enable_a, dir_match_value_a} <= 3'($random(seed));
            cmp_b_value <= 16'($random(seed));
            run <= 1;
            repeat (30) @(posedge sys_clk);
            run <= 0;
            {reset_end_run, debug_module_enable, trace_begin} <= 3'($random(seed));
            reset_event <= 1;
            @(posedge sys_clk);
            reset_event <= 0;
            if (!(reset_end_run && debug_module_enable && !trace_begin)) mreg = 0;
            apb(0, 8'h24, 0);
            chk("register", {24'h0, mreg}, rd);
        end
        stop_test;
    end
endmodule
`default_nettype wire

// ===== verification/dcbx_top_chk.sv
// Port checks for the comparator B extension block
`timescale 1ns/100ps
`default_nettype none
module dcbx_top_chk (
    input wire logic sys_clk, nrst, pready, pwrite,
    input wire logic [31:0] prdata,
    input wire logic reset_event, reset_end_run, debug_module_enable, trace_begin,
    input wire logic full_mode, dir_qualify_enable_a, dir_match_value_a,
    input wire logic [15:0] cmp_b_value, cpu_addr,
    input wire logic bus_read, ppage_sel, linear_sel,
    input wire logic [2:0] ppage,
    input wire logic [16:0] linear_addr, core_addr_seen,
    input wire logic [7:0] core_data,
    input wire logic match_b, dir_qualify_enable_b, dir_match_value_b,
    input wire logic page_qualify_select, addr16_value
);
    logic [16:0] form;
    logic [3:0] bits;
    assign form = ppage_sel ? {ppage, cpu_addr[13:0]} : linear_sel ? linear_addr : {1'b0, cpu_addr};
    assign bits = {dir_qualify_enable_b, dir_match_value_b, page_qualify_select, addr16_value};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_keep;
        reset_event && reset_end_run && debug_module_enable && !trace_begin;
    endsequence
    sequence s_clear;
        reset_event && !(reset_end_run && debug_module_enable && !trace_begin);
    endsequence
    chk_dir_write: assert property (
        !full_mode && dir_qualify_enable_b && !dir_match_value_b && bus_read |=> !match_b)
        else $error("write-only match hit a read");
    chk_dir_read: assert property (
        !full_mode && dir_qualify_enable_b && dir_match_value_b && !bus_read |=> !match_b)
        else $error("read-only match hit a write");
    chk_full_dir: assert property (
        full_mode && dir_qualify_enable_a && bus_read != dir_match_value_a |=> !match_b)
        else $error("data mode ignored A direction");
    chk_page_qual: assert property (
        !full_mode && page_qualify_select != ppage_sel |=> !match_b)
        else $error("page qualifier ignored");
    chk_addr_form: assert property (1'b1 |=> core_addr_seen == $past(form))
        else $error("formed address wrong");
    chk_bit16_cmp: assert property (!full_mode && form[16] != addr16_value |=> !match_b)
        else $error("bit 16 compare ignored");
    chk_data_mode: assert property (
        full_mode && core_data != cmp_b_value[7:0] |=> !match_b)
        else $error("data mode hit on wrong data");
    chk_reset_clear: assert property (s_clear |=> bits == 4'h0)
        else $error("reset did not clear");
    chk_reset_keep: assert property (s_keep |=> $stable(bits))
        else $error("end-run reset changed bits");
    chk_unimpl_zero: assert property (pready && !pwrite |-> prdata[4:1] == 4'h0)
        else $error("unimplemented bits read nonzero");
endmodule
bind dcbx_top dcbx_top_chk i_dcbx_top_chk (.*);
`default_nettype wire

// ===== verilog/dcbx_addr_form.sv
// Forms the 17-bit core address seen by comparator B
`timescale 1ns/100ps
`default_nettype none
module dcbx_addr_form (
    input wire logic ppage_sel,
    input wire logic linear_sel,
    input wire logic [dcbx_pkg::DCBX_PAGE_W-1:0] ppage,
    input wire logic [dcbx_pkg::DCBX_CPU_ADDR_W-1:0] cpu_addr,
    input wire logic [dcbx_pkg::DCBX_CORE_ADDR_W-1:0] linear_addr,
    output logic [dcbx_pkg::DCBX_CORE_ADDR_W-1:0] core_addr
);
    import dcbx_pkg::*;

    always_comb begin
        if (ppage_sel) begin
            core_addr = {ppage, cpu_addr[DCBX_PAGE_OFS_W-1:0]};
        end else if (linear_sel) begin
            core_addr = linear_addr;
        end else begin
            core_addr = {1'b0, cpu_addr};
        end
    end
endmodule
`default_nettype wire

// ===== verilog/dcbx_match.sv
// Comparator B qualification and compare, address or data mode
`timescale 1ns/100ps
`default_nettype none
module dcbx_match (
    input wire logic full_mode,
    input wire logic bus_valid,
    input wire logic bus_read,
    input wire logic ppage_sel,
    input wire logic dir_qualify_enable_b,
    input wire logic dir_match_value_b,
    input wire logic dir_qualify_enable_a,
    input wire logic dir_match_value_a,
    input wire logic page_qualify_select,
    input wire logic addr16_value,
    input wire logic [dcbx_pkg::DCBX_CORE_ADDR_W-1:0] core_addr,
    input wire logic [dcbx_pkg::DCBX_DATA_CMP_W-1:0] core_data,
    input wire logic [dcbx_pkg::DCBX_CPU_ADDR_W-1:0] cmp_value,
    output logic hit
);
    import dcbx_pkg::*;

    logic dir_en;
    logic dir_val;
    logic dir_ok;
    logic page_ok;
    logic a16_ok;
    logic value_ok;

    always_comb begin
        // Full modes borrow comparator A direction controls
        dir_en = full_mode ? dir_qualify_enable_a : dir_qualify_enable_b;
        dir_val = full_mode ? dir_match_value_a : dir_match_value_b;
        // Value 1 selects reads, 0 selects writes
        dir_ok = !dir_en || (dir_val == bus_read);
        page_ok = full_mode || (page_qualify_select == ppage_sel);
        a16_ok = full_mode || (core_addr[DCBX_CORE_ADDR_W-1] == addr16_value);
        if (full_mode) begin
            value_ok = (core_data == cmp_value[DCBX_DATA_CMP_W-1:0]);
        end else begin
            value_ok = (core_addr[DCBX_CPU_ADDR_W-1:0] == cmp_value);
        end
        hit = bus_valid && dir_ok && page_ok && a16_ok && value_ok;
    end
endmodule
`default_nettype wire

// ===== verilog/dcbx_top.sv
// Comparator B extension register with APB access and registered match
`timescale 1ns/100ps
`default_nettype none
module dcbx_top #(
    parameter int ADDR_W = dcbx_pkg::DCBX_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [dcbx_pkg::DCBX_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [dcbx_pkg::DCBX_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // System reset request, not power-on
    input wire logic reset_event,
    input wire logic reset_end_run,
    input wire logic debug_module_enable,
    input wire logic trace_begin,
    // Mode, comparator A controls and comparator B value from the rest of the debug module
    input wire logic full_mode,
    input wire logic dir_qualify_enable_a,
    input wire logic dir_match_value_a,
    input wire logic [dcbx_pkg::DCBX_CPU_ADDR_W-1:0] cmp_b_value,
    // Core bus
    input wire logic bus_valid,
    input wire logic bus_read,
    input wire logic ppage_sel,
    input wire logic linear_sel,
    input wire logic [dcbx_pkg::DCBX_PAGE_W-1:0] ppage,
    input wire logic [dcbx_pkg::DCBX_CPU_ADDR_W-1:0] cpu_addr,
    input wire logic [dcbx_pkg::DCBX_CORE_ADDR_W-1:0] linear_addr,
    input wire logic [dcbx_pkg::DCBX_DATA_CMP_W-1:0] core_data,
    // Results
    output logic match_b,
    output logic [dcbx_pkg::DCBX_CORE_ADDR_W-1:0] core_addr_seen,
    output logic dir_qualify_enable_b,
    output logic dir_match_value_b,
    output logic page_qualify_select,
    output logic addr16_value
);
    import dcbx_pkg::*;

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must be 8 to 32");
    end

    typedef struct packed {
        logic [DCBX_REG_W-1:0] cbx;
        logic [DCBX_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic match;
        logic [DCBX_CORE_ADDR_W-1:0] addr;
    } dcbx_state_s;

    dcbx_state_s state_q;
    dcbx_state_s state_d;

    logic [DCBX_CORE_ADDR_W-1:0] formed_addr;
    logic hit;

    function automatic logic hits_cbx(input logic [ADDR_W-1:0] a);
        hits_cbx = (a == ADDR_W'(DCBX_CBX_BYTE_ADDR));
    endfunction

    dcbx_addr_form u_form (
        .ppage_sel(ppage_sel),
        .linear_sel(linear_sel),
        .ppage(ppage),
        .cpu_addr(cpu_addr),
        .linear_addr(linear_addr),
        .core_addr(formed_addr)
    );

    // Matches against the live register value, so a write lands on the next compare
    dcbx_match u_match (
        .full_mode(full_mode),
        .bus_valid(bus_valid),
        .bus_read(bus_read),
        .ppage_sel(ppage_sel),
        .dir_qualify_enable_b(state_q.cbx[DCBX_BIT_DIR_EN]),
        .dir_match_value_b(state_q.cbx[DCBX_BIT_DIR_VAL]),
        .dir_qualify_enable_a(dir_qualify_enable_a),
        .dir_match_value_a(dir_match_value_a),
        .page_qualify_select(state_q.cbx[DCBX_BIT_PAGE_SEL]),
        .addr16_value(state_q.cbx[DCBX_BIT_ADDR16]),
        .core_addr(formed_addr),
        .core_data(core_data),
        .cmp_value(cmp_b_value),
        .hit(hit)
    );

    logic keep_on_reset;
    logic access;

    always_comb begin
        state_d = state_q;
        // End-trace reset with debug on and no begin trigger leaves bits alone
        keep_on_reset = reset_end_run && debug_module_enable && !trace_begin;
        access = psel && penable;

        // First access cycle: prepare answer; second: complete with pready high
        state_d.pready = 1'b0;
        state_d.pslverr = 1'b0;
        if (access && !state_q.pready) begin
            state_d.pready = 1'b1;
            if (hits_cbx(paddr)) begin
                state_d.prdata = {24'h000000, state_q.cbx & DCBX_IMPL_MASK};
            end else begin
                state_d.prdata = 32'h00000000;
                state_d.pslverr = 1'b1;
            end
            if (pwrite) begin
                state_d.prdata = 32'h00000000;
            end
        end else if (access && state_q.pready) begin
            state_d.prdata = state_q.prdata;
        end

        // Reset request outranks a write landing in the same cycle
        if (reset_event) begin
            if (!keep_on_reset) begin
                state_d.cbx = DCBX_CBX_RESET;
            end
        end else if (access && state_q.pready && pwrite && pstrb[0] && hits_cbx(paddr)) begin
            state_d.cbx = pwdata[DCBX_REG_W-1:0] & DCBX_IMPL_MASK;
        end

        state_d.match = hit;
        state_d.addr = formed_addr;
    end

    // Power-on reset clears everything
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign match_b = state_q.match;
    assign core_addr_seen = state_q.addr;
    assign dir_qualify_enable_b = state_q.cbx[DCBX_BIT_DIR_EN];
    assign dir_match_value_b = state_q.cbx[DCBX_BIT_DIR_VAL];
    assign page_qualify_select = state_q.cbx[DCBX_BIT_PAGE_SEL];
    assign addr16_value = state_q.cbx[DCBX_BIT_ADDR16];
endmodule
`default_nettype wire
